/* hw/cpu_pointer_pkg.sv */
package cpu_pointer_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;
    localparam int STACK_W = 4;
    localparam int OFFSET_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_PC = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SP = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IV = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LC0 = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_LC1 = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_OFFS = 8'h14;

    localparam logic [WORD_W-1:0] RST_PC = 16'h8000;
    localparam logic [STACK_W-1:0] RST_SP = 4'hF;
    localparam logic [WORD_W-1:0] RST_IV = 16'h0000;
    localparam logic [WORD_W-1:0] RST_LC = 16'h0000;
    localparam logic [OFFSET_W-1:0] RST_OFFS = 8'h00;

    localparam logic [WORD_W-1:0] STEP = 16'h0001;
    localparam logic [STACK_W-1:0] STACK_STEP = 4'h1;
    localparam logic [OFFSET_W-1:0] OFFSET_STEP = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        FP_HOLD,
        FP_INC,
        FP_DEC,
        FP_SPARE
    } fp_mode_t;

endpackage

/* hw/cpu_pointer_system_registers.sv */
`timescale 1ns/10ps

module cpu_pointer_system_registers (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        fetch,
    input  wire logic        stackPush,
    input  wire logic        stackPop,
    input  wire logic        intAck,
    input  wire logic        loopDec,
    input  wire logic        loopSel,
    input  wire logic [15:0] loopTarget,
    input  wire logic        fpAccess,
    input  wire logic        fpWrite,
    input  wire logic [1:0]  fpMode,
    input  wire logic [15:0] frameBase,
    output logic [15:0]      programCounter,
    output logic [3:0]       stackTopPointer,
    output logic [15:0]      frameAddress,
    output logic             fpValid,
    output logic             callPush,
    output logic [15:0]      callReturn
);

    function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        mergeBytes = {strb[1] ? data[15:8] : old[15:8],
                      strb[0] ? data[7:0] : old[7:0]};
    endfunction

    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr == cpu_pointer_pkg::ADDR_PC) || (addr == cpu_pointer_pkg::ADDR_SP)
                 || (addr == cpu_pointer_pkg::ADDR_IV) || (addr == cpu_pointer_pkg::ADDR_LC0)
                 || (addr == cpu_pointer_pkg::ADDR_LC1)
                 || (addr == cpu_pointer_pkg::ADDR_OFFS);
    endfunction

    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [3:0]  sp_reg;
    logic [3:0]  sp_next;
    logic [15:0] iv_reg;
    logic [15:0] iv_next;
    logic [15:0] lc0_reg;
    logic [15:0] lc0_next;
    logic [15:0] lc1_reg;
    logic [15:0] lc1_next;
    logic [7:0]  offs_reg;
    logic [7:0]  offs_next;
    logic [15:0] fpAddr_reg;
    logic [15:0] fpAddr_next;
    logic        fpValid_reg;
    logic        callPush_reg;
    logic [15:0] callRet_reg;

    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;

    wire awFire = s_axi_awvalid && awready_reg;
    wire wFire = s_axi_wvalid && wready_reg;
    // Both halves held, response not yet raised: commit exactly once
    wire wrFire = !awready_reg && !wready_reg && !bvalid_reg;
    wire arFire = s_axi_arvalid && arready_reg;
    wire wrPc = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_PC);
    wire wrSp = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_SP);
    wire wrIv = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_IV);
    wire wrLc0 = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_LC0);
    wire wrLc1 = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_LC1);
    wire wrOffs = wrFire && (awaddr_reg == cpu_pointer_pkg::ADDR_OFFS);

    // Loop counters
    wire         dec0 = loopDec && !loopSel;
    wire         dec1 = loopDec && loopSel;
    wire [15:0]  lc0Dec = lc0_reg - cpu_pointer_pkg::STEP;
    wire [15:0]  lc1Dec = lc1_reg - cpu_pointer_pkg::STEP;
    wire [15:0]  lcDec = loopSel ? lc1Dec : lc0Dec;
    // Branch taken while the counter has not reached zero
    wire         loopJump = loopDec && (lcDec != 16'h0000);

    assign lc0_next = dec0 ? lc0Dec
                    : wrLc0 ? mergeBytes(lc0_reg, wdata_reg, wstrb_reg) : lc0_reg;
    assign lc1_next = dec1 ? lc1Dec
                    : wrLc1 ? mergeBytes(lc1_reg, wdata_reg, wstrb_reg) : lc1_reg;

    // Interrupt and loop branch win over a bus write, a bus write wins over fetch; the core is expected to stall around it
    assign pc_next = intAck ? iv_reg
                   : loopJump ? loopTarget
                   : wrPc ? mergeBytes(pc_reg, wdata_reg, wstrb_reg)
                   : fetch ? pc_reg + cpu_pointer_pkg::STEP : pc_reg;

    wire        spUp = stackPush || intAck;
    wire [3:0]  spInc = spUp ? cpu_pointer_pkg::STACK_STEP : 4'h0;
    wire [3:0]  spDecr = stackPop ? cpu_pointer_pkg::STACK_STEP : 4'h0;
    // Four-bit sum wraps on its own
    assign sp_next = (spUp || stackPop) ? sp_reg + spInc - spDecr
                   : wrSp ? (wstrb_reg[0] ? wdata_reg[3:0] : sp_reg) : sp_reg;

    assign iv_next = wrIv ? mergeBytes(iv_reg, wdata_reg, wstrb_reg) : iv_reg;

    // Frame offset stepping
    wire        fpStep = fpAccess
                         && (fpMode == cpu_pointer_pkg::FP_INC || fpMode == cpu_pointer_pkg::FP_DEC);
    wire [7:0]  offsStepped = (fpMode == cpu_pointer_pkg::FP_INC)
                              ? offs_reg + cpu_pointer_pkg::OFFSET_STEP
                              : offs_reg - cpu_pointer_pkg::OFFSET_STEP;
    assign offs_next = fpStep ? offsStepped
                     : (wrOffs && wstrb_reg[0]) ? wdata_reg[7:0] : offs_reg;

    // Writes use the stepped offset, reads the current one
    wire [7:0]  offsUsed = (fpWrite && fpStep) ? offsStepped : offs_reg;
    assign fpAddr_next = fpAccess ? frameBase + {8'h00, offsUsed} : fpAddr_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc_reg <= cpu_pointer_pkg::RST_PC;
            sp_reg <= cpu_pointer_pkg::RST_SP;
            iv_reg <= cpu_pointer_pkg::RST_IV;
            lc0_reg <= cpu_pointer_pkg::RST_LC;
            lc1_reg <= cpu_pointer_pkg::RST_LC;
            offs_reg <= cpu_pointer_pkg::RST_OFFS;
            fpAddr_reg <= 16'h0000;
            fpValid_reg <= 1'b0;
            callPush_reg <= 1'b0;
            callRet_reg <= 16'h0000;
        end else begin
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            iv_reg <= iv_next;
            lc0_reg <= lc0_next;
            lc1_reg <= lc1_next;
            offs_reg <= offs_next;
            fpAddr_reg <= fpAddr_next;
            fpValid_reg <= fpAccess;
            callPush_reg <= intAck;
            callRet_reg <= intAck ? pc_reg : callRet_reg;
        end
    end

    // Read mux; reserved bits above each field read zero
    wire [31:0] rdMux =
        (s_axi_araddr == cpu_pointer_pkg::ADDR_PC) ? {16'h0000, pc_reg}
      : (s_axi_araddr == cpu_pointer_pkg::ADDR_SP) ? {28'h0000000, sp_reg}
      : (s_axi_araddr == cpu_pointer_pkg::ADDR_IV) ? {16'h0000, iv_reg}
      : (s_axi_araddr == cpu_pointer_pkg::ADDR_LC0) ? {16'h0000, lc0_reg}
      : (s_axi_araddr == cpu_pointer_pkg::ADDR_LC1) ? {16'h0000, lc1_reg}
      : (s_axi_araddr == cpu_pointer_pkg::ADDR_OFFS) ? {24'h000000, offs_reg}
      : 32'h00000000;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (awFire) begin
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                awready_reg <= 1'b1;
            end
            if (wFire) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= cpu_pointer_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= isMapped(awaddr_reg) ? cpu_pointer_pkg::RESP_OKAY
                                              : cpu_pointer_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= cpu_pointer_pkg::RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else if (arFire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rdMux;
            rresp_reg <= isMapped(s_axi_araddr) ? cpu_pointer_pkg::RESP_OKAY
                                                : cpu_pointer_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign programCounter = pc_reg;
    assign stackTopPointer = sp_reg;
    assign frameAddress = fpAddr_reg;
    assign fpValid = fpValid_reg;
    assign callPush = callPush_reg;
    assign callReturn = callRet_reg;

    // Helper: no program counter source other than a fetch
    wire pcQuiet = !intAck && !loopJump && !wrPc;

    property p_resetPc;
        @(posedge clk_sys) $rose(arst_n)
        |-> pc_reg == cpu_pointer_pkg::RST_PC && sp_reg == cpu_pointer_pkg::RST_SP;
    endproperty
    a_resetPc: assert property (p_resetPc) else $error("Reset values wrong");

    property p_fetchStep;
        @(posedge clk_sys) disable iff (!arst_n)
        fetch && pcQuiet |=> pc_reg == $past(pc_reg) + 16'h0001;
    endproperty
    a_fetchStep: assert property (p_fetchStep) else $error("Fetch step wrong");

    property p_pcWrite;
        @(posedge clk_sys) disable iff (!arst_n)
        wrPc && !intAck && !loopJump && wstrb_reg[1:0] == 2'h3
        |=> pc_reg == $past(wdata_reg[15:0]);
    endproperty
    a_pcWrite: assert property (p_pcWrite) else $error("Redirect lost");

    property p_pcRead;
        @(posedge clk_sys) disable iff (!arst_n)
        arFire && !fetch && pcQuiet |=> $stable(pc_reg) && rvalid_reg;
    endproperty
    a_pcRead: assert property (p_pcRead) else $error("Read moved counter");

    property p_spRead;
        @(posedge clk_sys) disable iff (!arst_n)
        arFire && s_axi_araddr == cpu_pointer_pkg::ADDR_SP
        |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0000000;
    endproperty
    a_spRead: assert property (p_spRead) else $error("Reserved bits set");

    property p_spPush;
        @(posedge clk_sys) disable iff (!arst_n)
        stackPush && !stackPop |=> sp_reg == 4'($past(sp_reg) + 4'h1);
    endproperty
    a_spPush: assert property (p_spPush) else $error("Push step wrong");

    property p_spPop;
        @(posedge clk_sys) disable iff (!arst_n)
        stackPop && !stackPush && !intAck |=> sp_reg == 4'($past(sp_reg) - 4'h1);
    endproperty
    a_spPop: assert property (p_spPop) else $error("Pop step wrong");

    property p_intCall;
        @(posedge clk_sys) disable iff (!arst_n)
        intAck |=> pc_reg == $past(iv_reg) && callPush && callReturn == $past(pc_reg);
    endproperty
    a_intCall: assert property (p_intCall) else $error("Vector call wrong");

    property p_loopZero;
        @(posedge clk_sys) disable iff (!arst_n)
        dec0 |=> lc0_reg == 16'($past(lc0_reg) - 16'h0001)
                 && (lc0_reg == 16'h0000 || intAck || pc_reg == $past(loopTarget) || $past(intAck));
    endproperty
    a_loopZero: assert property (p_loopZero) else $error("Loop zero wrong");

    property p_fpRead;
        @(posedge clk_sys) disable iff (!arst_n)
        fpAccess && !fpWrite
        |=> fpValid && frameAddress == 16'($past(frameBase) + {8'h00, $past(offs_reg)});
    endproperty
    a_fpRead: assert property (p_fpRead) else $error("Frame read address wrong");

    property p_fpPreInc;
        @(posedge clk_sys) disable iff (!arst_n)
        fpAccess && fpWrite && fpMode == cpu_pointer_pkg::FP_INC
        |=> offs_reg == 8'($past(offs_reg) + 8'h01)
            && frameAddress == 16'($past(frameBase) + {8'h00, offs_reg});
    endproperty
    a_fpPreInc: assert property (p_fpPreInc) else $error("Pre-increment wrong");

    property p_fpPreDec;
        @(posedge clk_sys) disable iff (!arst_n)
        fpAccess && fpWrite && fpMode == cpu_pointer_pkg::FP_DEC
        |=> offs_reg == 8'($past(offs_reg) - 8'h01)
            && frameAddress == 16'($past(frameBase) + {8'h00, offs_reg});
    endproperty
    a_fpPreDec: assert property (p_fpPreDec) else $error("Pre-decrement wrong");

    property p_fpPostDec;
        @(posedge clk_sys) disable iff (!arst_n)
        fpAccess && !fpWrite && fpMode == cpu_pointer_pkg::FP_DEC
        |=> offs_reg == 8'($past(offs_reg) - 8'h01);
    endproperty
    a_fpPostDec: assert property (p_fpPostDec) else $error("Post-decrement wrong");

    property p_loopOne;
        @(posedge clk_sys) disable iff (!arst_n)
        dec1 |=> lc1_reg == 16'($past(lc1_reg) - 16'h0001);
    endproperty
    a_loopOne: assert property (p_loopOne) else $error("Loop one wrong");

    // Counter about to leave one behind nonzero: branch taken
    property p_loopJump;
        @(posedge clk_sys) disable iff (!arst_n)
        loopDec && !intAck && (loopSel ? lc1_reg : lc0_reg) != 16'h0001
        |=> pc_reg == $past(loopTarget);
    endproperty
    a_loopJump: assert property (p_loopJump) else $error("Loop branch lost");

    property p_loopStay;
        @(posedge clk_sys) disable iff (!arst_n)
        loopDec && !intAck && !wrPc && !fetch && (loopSel ? lc1_reg : lc0_reg) == 16'h0001
        |=> $stable(pc_reg);
    endproperty
    a_loopStay: assert property (p_loopStay) else $error("Loop fell through wrong");

    property p_ivWrite;
        @(posedge clk_sys) disable iff (!arst_n)
        wrIv && wstrb_reg[1:0] == 2'h3 |=> iv_reg == $past(wdata_reg[15:0]);
    endproperty
    a_ivWrite: assert property (p_ivWrite) else $error("Vector write lost");

endmodule

/* verif/tb.sv */
`timescale 1ns/10ps

module tb;
    localparam logic [1:0] OK      = cpu_pointer_pkg::RESP_OKAY;
    localparam logic [1:0] ERR     = cpu_pointer_pkg::RESP_SLVERR;
    localparam logic [9:0] F_FETCH = 10'h200;
    localparam logic [9:0] F_PUSH  = 10'h100;
    localparam logic [9:0] F_POP   = 10'h080;
    localparam logic [9:0] F_ACK   = 10'h040;
    localparam logic [9:0] F_DEC   = 10'h020;
    localparam logic [9:0] F_SEL   = 10'h010;
    localparam logic [9:0] F_FP    = 10'h008;

    logic        clk_sys;
    logic        arst_n;
    logic [7:0]  awAddr, arAddr, offs, step;
    logic [31:0] wData, rData, rnd, seed;
    logic [3:0]  wStrb, stackTopPointer, sp;
    logic        awValid, wValid, bReady, arValid, rReady;
    logic        awReady, wReady, bValid, arReady, rValid, fpValid, callPush;
    logic [1:0]  bResp, rResp;
    logic [9:0]  strobes;
    logic [15:0] loopTarget, frameBase, programCounter, frameAddress, callReturn;
    logic [15:0] pc, iv, v;
    logic [15:0] lc [2];
    int          err_count, comparisons, cycles;

    cpu_pointer_system_registers DUT (
        .clk_sys(clk_sys), .arst_n(arst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .fetch(strobes[9]), .stackPush(strobes[8]), .stackPop(strobes[7]),
        .intAck(strobes[6]), .loopDec(strobes[5]), .loopSel(strobes[4]),
        .loopTarget(loopTarget), .fpAccess(strobes[3]), .fpWrite(strobes[2]),
        .fpMode(strobes[1:0]), .frameBase(frameBase),
        .programCounter(programCounter), .stackTopPointer(stackTopPointer),
        .frameAddress(frameAddress), .fpValid(fpValid), .callPush(callPush),
        .callReturn(callReturn)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk_sys);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk_sys);
            if (!awDone && awReady === 1'b1) begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1) begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bValid !== 1'b1);
        bReady <= 1'b0;
        chk("bresp", 32'(er), 32'(bResp));
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk_sys); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clk_sys); while (rValid !== 1'b1);
        rReady <= 1'b0;
        chk("rdata", exp, rData);
        chk("rresp", 32'(er), 32'(rResp));
    endtask

    // One-cycle core strobe; returns just after the edge that samples it
    task automatic core(input logic [9:0] s, input logic [15:0] t, input logic [15:0] b);
        @(posedge clk_sys);
        strobes <= s;
        loopTarget <= t;
        frameBase <= b;
        @(posedge clk_sys);
        strobes <= 10'h000;
        #1;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        seed = 32'h0001126F;
        arst_n = 1'b0;
        {awAddr, arAddr, wData, wStrb, awValid, wValid, bReady, arValid, rReady} = '0;
        {strobes, loopTarget, frameBase} = '0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        axi_read(cpu_pointer_pkg::ADDR_PC, 32'h0000_8000, OK);
        axi_read(cpu_pointer_pkg::ADDR_SP, 32'h0000_000F, OK);
        axi_read(cpu_pointer_pkg::ADDR_IV, 32'h0, OK);
        axi_read(cpu_pointer_pkg::ADDR_LC0, 32'h0, OK);
        axi_read(cpu_pointer_pkg::ADDR_LC1, 32'h0, OK);
        axi_read(cpu_pointer_pkg::ADDR_OFFS, 32'h0, OK);
        pc = 16'h8000;
        sp = 4'hF;
        lc[0] = 16'h0;
        lc[1] = 16'h0;
        axi_write(8'h18, 32'hFFFF_FFFF, 4'hF, ERR);
        axi_read(8'h18, 32'h0, ERR);
        axi_read(8'hFC, 32'h0, ERR);
        repeat (24) begin
            rnd = next_rand();
            if (rnd[0]) begin
                core(F_FETCH, 16'h0000, 16'h0000);
                pc = pc + 16'h0001;
            end else begin
                axi_read(cpu_pointer_pkg::ADDR_PC, 32'(pc), OK);
            end
            chk("programCounter", 32'(pc), 32'(programCounter));
        end
        rnd = next_rand();
        axi_write(cpu_pointer_pkg::ADDR_PC, rnd, 4'h3, OK);
        pc = rnd[15:0] + 16'h0001;
        core(F_FETCH, 16'h0000, 16'h0000);
        chk("programCounter", 32'(pc), 32'(programCounter));
        axi_write(cpu_pointer_pkg::ADDR_PC, 32'h0000_12AB, 4'h1, OK);
        pc = {pc[15:8], 8'hAB};
        chk("programCounter", 32'(pc), 32'(programCounter));
        axi_write(cpu_pointer_pkg::ADDR_SP, 32'hFFFF_FFF3, 4'hF, OK);
        axi_read(cpu_pointer_pkg::ADDR_SP, 32'h0000_0003, OK);
        sp = 4'h3;
        repeat (40) begin
            rnd = next_rand();
            core({1'b0, rnd[1:0], 7'h00}, 16'h0000, 16'h0000);
            sp = sp + 4'(rnd[1]) - 4'(rnd[0]);
            chk("stackTopPointer", 32'(sp), 32'(stackTopPointer));
        end
        // Forced wrap both ways, the random walk may not reach the ends
        axi_write(cpu_pointer_pkg::ADDR_SP, 32'h0, 4'h1, OK);
        core(F_POP, 16'h0000, 16'h0000);
        chk("stackTopPointer", 32'hF, 32'(stackTopPointer));
        core(F_PUSH, 16'h0000, 16'h0000);
        chk("stackTopPointer", 32'h0, 32'(stackTopPointer));
        axi_read(cpu_pointer_pkg::ADDR_SP, 32'h0, OK);
        rnd = next_rand();
        iv = rnd[15:0];
        axi_write(cpu_pointer_pkg::ADDR_IV, rnd, 4'h3, OK);
        axi_read(cpu_pointer_pkg::ADDR_IV, 32'(iv), OK);
        core(F_ACK, 16'h0000, 16'h0000);
        chk("callPush", 32'h1, 32'(callPush));
        chk("callReturn", 32'(pc), 32'(callReturn));
        chk("programCounter", 32'(iv), 32'(programCounter));
        chk("stackTopPointer", 32'h1, 32'(stackTopPointer));
        pc = iv;
        @(posedge clk_sys);
        #1;
        chk("callPush", 32'h0, 32'(callPush));
        for (int i = 0; i < 8; i++) begin
            rnd = next_rand();
            v = (i < 6) ? 16'(i % 3) : rnd[31:16];
            axi_write(i[0] ? cpu_pointer_pkg::ADDR_LC1 : cpu_pointer_pkg::ADDR_LC0,
                      32'(v), 4'h3, OK);
            core(F_DEC | (i[0] ? F_SEL : 10'h000), rnd[15:0], 16'h0000);
            lc[i[0]] = v - 16'h0001;
            if (lc[i[0]] !== 16'h0000) pc = rnd[15:0];
            chk("programCounter", 32'(pc), 32'(programCounter));
            axi_read(cpu_pointer_pkg::ADDR_LC0, 32'(lc[0]), OK);
            axi_read(cpu_pointer_pkg::ADDR_LC1, 32'(lc[1]), OK);
        end
        for (int i = 0; i < 24; i++) begin
            rnd = next_rand();
            if (i < 4) begin
                offs = i[0] ? 8'h00 : 8'hFF;
                rnd[2:0] = (i == 0) ? 3'h1 : (i == 1) ? 3'h6 : (i == 2) ? 3'h5 : 3'h2;
            end else if (rnd[8]) begin
                offs = rnd[23:16];
            end
            axi_write(cpu_pointer_pkg::ADDR_OFFS, 32'(offs), 4'h1, OK);
            step = (rnd[1:0] == 2'h1) ? 8'h01 : (rnd[1:0] == 2'h2) ? 8'hFF : 8'h00;
            if (rnd[2]) offs = offs + step;
            v = rnd[31:16] + {8'h00, offs};
            if (!rnd[2]) offs = offs + step;
            core(F_FP | 10'(rnd[2:0]), 16'h0000, rnd[31:16]);
            chk("fpValid", 32'h1, 32'(fpValid));
            chk("frameAddress", 32'(v), 32'(frameAddress));
            axi_read(cpu_pointer_pkg::ADDR_OFFS, 32'(offs), OK);
            chk("fpValid", 32'h0, 32'(fpValid));
        end
        @(posedge clk_sys);
        arst_n <= 1'b0;
        #1;
        chk("programCounter", 32'h8000, 32'(programCounter));
        chk("stackTopPointer", 32'hF, 32'(stackTopPointer));
        @(posedge clk_sys);
        arst_n <= 1'b1;
        axi_read(cpu_pointer_pkg::ADDR_OFFS, 32'h0, OK);
        axi_read(cpu_pointer_pkg::ADDR_LC1, 32'h0, OK);
        axi_read(cpu_pointer_pkg::ADDR_IV, 32'h0, OK);
        print_verdict();
    end
endmodule
